// file: logic/rtc_status_monitor.sv
// status monitor, trimmed second timebase and interrupt pin logic of the rtc
// assumes a serial engine giving a one-cycle register write strobe on clk_sys,
// time counters giving same-clock match and rollover pulses, and async comparators
module rtc_status_monitor
    import rtc_mon_pkg::*;
#(
    parameter int unsigned OSC_HALT_LIMIT = rtc_mon_pkg::OSC_HALT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic osc_clk,
    input wire logic supply_below_1v6,
    input wire logic supply_below_1v3,
    input wire logic reg_wr,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic weekly_alarm_match,
    input wire logic daily_alarm_match,
    input wire logic minute_rollover,
    input wire logic hour_rollover,
    input wire logic month_rollover,
    output logic second_tick,
    output logic hour_format,
    output logic test_mode,
    output logic clock_out_active,
    output logic supply_sample_en,
    output logic irq_n_pin_o,
    output logic irq_n_pin_oe
);

    import rtc_mon_pkg::*;

    localparam int unsigned HALT_W = $clog2(OSC_HALT_LIMIT + 1);
    localparam logic [HALT_W-1:0] HALT_LAST = HALT_W'(OSC_HALT_LIMIT - 1);
    localparam logic [HALT_W-1:0] HALT_ONE = HALT_W'(1);
    localparam logic [16:0] TICK_ONE = 17'h00001;
    localparam logic [5:0] SEC_ONE = 6'h01;

    // ========================================================================
    // synchronised inputs and oscillator edge
    logic [2:0] sync_out;
    logic osc_lvl;
    logic below_hi;
    logic below_lo;
    logic osc_prev_q;
    logic osc_tick;

    level_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din({osc_clk, supply_below_1v3, supply_below_1v6}),
        .dout(sync_out)
    );

    assign osc_lvl = sync_out[2];
    assign below_lo = sync_out[1];
    assign below_hi = sync_out[0];
    assign osc_tick = osc_lvl & ~osc_prev_q;

    // ========================================================================
    // register state
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_a_d;
    logic [7:0] trim_q;
    logic [7:0] trim_d;
    logic vsel_q, vsel_d;
    logic lowv_q, lowv_d;
    logic oscr_q, oscr_d;
    logic pon_q, pon_d;
    logic clkdis_a_q, clkdis_a_d;
    logic pflag_q, pflag_d;
    logic wflag_q, wflag_d;
    logic dflag_q, dflag_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // write strobes per register
    logic wr_a;
    logic wr_b;
    logic wr_t;
    assign wr_a = reg_wr & (reg_addr == CTRL_A_ADDR);
    assign wr_b = reg_wr & (reg_addr == CTRL_B_ADDR);
    assign wr_t = reg_wr & (reg_addr == TRIM_ADDR);

    // field views
    logic weekly_en;
    logic daily_en;
    logic clkdis_b;
    periodic_sel_t psel;
    logic trim_long;
    logic [6:0] trim_val;
    assign weekly_en = ctrl_a_q[A_WEEKLY_EN];
    assign daily_en = ctrl_a_q[A_DAILY_EN];
    assign clkdis_b = ctrl_a_q[A_CLK_DIS_B];
    assign psel = periodic_sel_t'(ctrl_a_q[A_PSEL_MSB:A_PSEL_LSB]);
    assign trim_long = trim_q[T_INTERVAL];
    assign trim_val = trim_q[T_VALUE_MSB:0];

    // host clear requests: a 0 written to the bit
    logic clr_lowv;
    logic clr_pon;
    logic clr_pflag;
    logic clr_wflag;
    logic clr_dflag;
    assign clr_lowv = wr_b & ~reg_wdata[B_LOWV];
    assign clr_pon = wr_b & ~reg_wdata[B_PON];
    assign clr_pflag = wr_b & ~reg_wdata[B_PFLAG];
    assign clr_wflag = wr_b & ~reg_wdata[B_WFLAG];
    assign clr_dflag = wr_b & ~reg_wdata[B_DFLAG];

    // ========================================================================
    // trimmed one-second timebase
    logic [16:0] tick_cnt_q;
    logic [16:0] tick_cnt_d;
    logic [5:0] sec_idx_q;
    logic [5:0] sec_idx_d;
    logic [5:0] sec_period;
    logic adj_slot;
    logic [16:0] adj_ext;
    logic [16:0] adj_short;
    logic trim_pos;
    logic trim_neg;
    logic [16:0] sec_len;
    logic sec_end;
    logic second_tick_q;

    // only one second in each interval is stretched or shortened
    assign sec_period = trim_long ? TRIM_SECS_LONG : TRIM_SECS_SHORT;
    assign adj_slot = (sec_idx_q == 6'h00);
    assign trim_pos = (trim_val >= TRIM_POS_MIN) & (trim_val <= TRIM_POS_MAX);
    assign trim_neg = (trim_val >= TRIM_NEG_MIN);
    assign adj_ext = 17'({trim_val - TRIM_ONE, 1'b0});
    assign adj_short = 17'({TRIM_ZERO - trim_val, 1'b0});
    assign sec_len = !adj_slot ? SEC_TICKS :
                     trim_pos ? SEC_TICKS + adj_ext :
                     trim_neg ? SEC_TICKS - adj_short : SEC_TICKS;
    assign sec_end = osc_tick & (tick_cnt_q >= sec_len - TICK_ONE);
    assign tick_cnt_d = sec_end ? 17'h00000 : (osc_tick ? tick_cnt_q + TICK_ONE : tick_cnt_q);
    assign sec_idx_d = !sec_end ? sec_idx_q :
                       (sec_idx_q >= sec_period - SEC_ONE) ? 6'h00 : sec_idx_q + SEC_ONE;

    // pulse-mode waveforms fall at each second boundary
    logic pulse_1hz_low;
    logic pulse_2hz_low;
    assign pulse_1hz_low = (tick_cnt_q < HALF_TICKS);
    assign pulse_2hz_low = (tick_cnt_q < QUARTER_TICKS) |
                           ((tick_cnt_q >= HALF_TICKS) & (tick_cnt_q < HALF_TICKS + QUARTER_TICKS));

    // timebase counters; the clock output path never sees the trim
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_q <= 1'b0;
            tick_cnt_q <= 17'h00000;
            sec_idx_q <= 6'h00;
            second_tick_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_lvl;
            tick_cnt_q <= tick_cnt_d;
            sec_idx_q <= sec_idx_d;
            second_tick_q <= sec_end;
        end
    end

    // ========================================================================
    // oscillator halt detection
    logic [HALT_W-1:0] halt_cnt_q;
    logic [HALT_W-1:0] halt_cnt_d;
    logic osc_halt;

    // a stalled oscillator leaves no edge for the whole window
    assign osc_halt = (halt_cnt_q == HALT_LAST);
    assign halt_cnt_d = osc_tick ? '0 : (osc_halt ? halt_cnt_q : halt_cnt_q + HALT_ONE);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            halt_cnt_q <= '0;
        end else begin
            halt_cnt_d_unused_guard: begin
                halt_cnt_q <= halt_cnt_d;
            end
        end
    end

    // ========================================================================
    // supply sampling window
    logic sample_active;
    logic below_sel;
    logic sample_en_q;

    // duty cycling saves comparator current; no sampling once a drop is held
    assign sample_active = (tick_cnt_q < SAMPLE_TICKS) & ~lowv_q & ~pon_q;
    assign below_sel = vsel_q ? below_lo : below_hi;

    // ========================================================================
    // interrupt sources
    logic level_evt;
    logic per_low;
    logic alarm_low;
    logic irq_low;
    logic weekly_set;
    logic daily_set;

    assign weekly_set = weekly_alarm_match & weekly_en;
    assign daily_set = daily_alarm_match & daily_en;

    // level-mode events and the pin request per periodic code
    always_comb begin
        level_evt = 1'b0;
        per_low = 1'b0;
        case (psel)
            PSEL_OFF: per_low = 1'b0;
            PSEL_LOW: per_low = 1'b1;
            PSEL_2HZ: per_low = pulse_2hz_low;
            PSEL_1HZ: per_low = pulse_1hz_low;
            PSEL_SEC: begin
                level_evt = sec_end;
                per_low = pflag_q;
            end
            PSEL_MIN: begin
                level_evt = minute_rollover;
                per_low = pflag_q;
            end
            PSEL_HOUR: begin
                level_evt = hour_rollover;
                per_low = pflag_q;
            end
            PSEL_MONTH: begin
                level_evt = month_rollover;
                per_low = pflag_q;
            end
            default: begin
                level_evt = 1'b0;
                per_low = 1'b0;
            end
        endcase
    end

    // flag and its enable both needed; clearing a flag releases its drive
    assign alarm_low = (wflag_q & weekly_en) | (dflag_q & daily_en);
    assign irq_low = per_low | alarm_low;

    // ========================================================================
    // next register values; hardware set wins over a host clear of pflag, wflag and dflag
    assign ctrl_a_d = pon_q ? REG_CLEAR : (wr_a ? reg_wdata : ctrl_a_q);
    assign trim_d = pon_q ? REG_CLEAR : (wr_t ? reg_wdata : trim_q);
    assign vsel_d = pon_q ? 1'b0 : (wr_b ? reg_wdata[B_VSEL] : vsel_q);
    assign clkdis_a_d = pon_q ? 1'b0 : (wr_b ? reg_wdata[B_CLK_DIS_A] : clkdis_a_q);
    assign pon_d = pon_q & ~clr_pon;
    assign lowv_d = pon_q ? 1'b0 : ((sample_active & below_sel) | (lowv_q & ~clr_lowv));
    assign oscr_d = osc_halt ? 1'b0 : (wr_b ? reg_wdata[B_OSCR] : oscr_q);
    assign pflag_d = pon_q ? 1'b0 : (level_evt | (pflag_q & ~clr_pflag));
    assign wflag_d = pon_q ? 1'b0 : (weekly_set | (wflag_q & ~clr_wflag));
    assign dflag_d = pon_q ? 1'b0 : (daily_set | (dflag_q & ~clr_dflag));

    // power-up from 0 V is the asynchronous reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a_q <= REG_CLEAR;
            trim_q <= REG_CLEAR;
            vsel_q <= 1'b0;
            clkdis_a_q <= 1'b0;
            pon_q <= PON_RESET;
            lowv_q <= 1'b0;
            oscr_q <= OSCR_RESET;
            pflag_q <= 1'b0;
            wflag_q <= 1'b0;
            dflag_q <= 1'b0;
        end else begin
            ctrl_a_q <= ctrl_a_d;
            trim_q <= trim_d;
            vsel_q <= vsel_d;
            clkdis_a_q <= clkdis_a_d;
            pon_q <= pon_d;
            lowv_q <= lowv_d;
            oscr_q <= oscr_d;
            pflag_q <= pflag_d;
            wflag_q <= wflag_d;
            dflag_q <= dflag_d;
        end
    end

    // ========================================================================
    // read back, registered; unmapped addresses read zero
    logic [7:0] status_b;
    assign status_b = {vsel_q, lowv_q, oscr_q, pon_q, clkdis_a_q, pflag_q, wflag_q, dflag_q};
    assign rdata_d = (reg_addr == CTRL_A_ADDR) ? ctrl_a_q :
                     (reg_addr == CTRL_B_ADDR) ? status_b :
                     (reg_addr == TRIM_ADDR) ? trim_q : REG_CLEAR;

    // ========================================================================
    // output flops
    logic irq_oe_q;
    logic clk_out_q;
    logic hour_fmt_q;
    logic test_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= REG_CLEAR;
            irq_oe_q <= 1'b0;
            clk_out_q <= 1'b0;
            hour_fmt_q <= 1'b0;
            test_q <= 1'b0;
            sample_en_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_oe_q <= irq_low;
            clk_out_q <= ~(clkdis_a_q & clkdis_b);
            hour_fmt_q <= ctrl_a_q[A_HOUR_FMT];
            test_q <= ctrl_a_q[A_TEST];
            sample_en_q <= sample_active;
        end
    end

    assign reg_rdata = rdata_q;
    assign second_tick = second_tick_q;
    assign hour_format = hour_fmt_q;
    assign test_mode = test_q;
    assign clock_out_active = clk_out_q;
    assign supply_sample_en = sample_en_q;
    assign irq_n_pin_o = 1'b0;
    assign irq_n_pin_oe = irq_oe_q;

endmodule

// file: logic/rtc_mon_pkg.sv
// constants, field layout and modes of the rtc status monitor and interrupt logic
// assumes a 125 MHz system clock and a 32.768 kHz oscillator sampled on it
package rtc_mon_pkg;

    // ========================================================================
    // register addresses (4-bit register index of the serial engine)
    localparam logic [3:0] TRIM_ADDR = 4'h7;
    localparam logic [3:0] CTRL_A_ADDR = 4'he;
    localparam logic [3:0] CTRL_B_ADDR = 4'hf;

    // ========================================================================
    // interrupt_enable_control field positions
    localparam int unsigned A_WEEKLY_EN = 7;
    localparam int unsigned A_DAILY_EN = 6;
    localparam int unsigned A_HOUR_FMT = 5;
    localparam int unsigned A_CLK_DIS_B = 4;
    localparam int unsigned A_TEST = 3;
    localparam int unsigned A_PSEL_MSB = 2;
    localparam int unsigned A_PSEL_LSB = 0;

    // ========================================================================
    // status_flag_control field positions
    localparam int unsigned B_VSEL = 7;
    localparam int unsigned B_LOWV = 6;
    localparam int unsigned B_OSCR = 5;
    localparam int unsigned B_PON = 4;
    localparam int unsigned B_CLK_DIS_A = 3;
    localparam int unsigned B_PFLAG = 2;
    localparam int unsigned B_WFLAG = 1;
    localparam int unsigned B_DFLAG = 0;

    // ========================================================================
    // trim register field positions
    localparam int unsigned T_INTERVAL = 7;
    localparam int unsigned T_VALUE_MSB = 6;

    // ========================================================================
    // reset values
    localparam logic [7:0] REG_CLEAR = 8'h00;
    localparam logic PON_RESET = 1'b1;
    localparam logic OSCR_RESET = 1'b0;

    // ========================================================================
    // periodic select codes
    typedef enum logic [2:0] {
        PSEL_OFF = 3'b000,
        PSEL_LOW = 3'b001,
        PSEL_2HZ = 3'b010,
        PSEL_1HZ = 3'b011,
        PSEL_SEC = 3'b100,
        PSEL_MIN = 3'b101,
        PSEL_HOUR = 3'b110,
        PSEL_MONTH = 3'b111
    } periodic_sel_t;

    // ========================================================================
    // timing
    localparam int unsigned SYS_CLK_HZ = 125_000_000;
    localparam int unsigned OSC_HZ = 32768;
    localparam logic [16:0] SEC_TICKS = 17'h08000;
    localparam logic [16:0] HALF_TICKS = 17'h04000;
    localparam logic [16:0] QUARTER_TICKS = 17'h02000;
    localparam int unsigned SAMPLE_TIME_US = 7800;
    localparam logic [16:0] SAMPLE_TICKS = 17'((SAMPLE_TIME_US * OSC_HZ + 999_999) / 1_000_000);
    localparam int unsigned OSC_HALT_TIME_US = 100;
    localparam int unsigned OSC_HALT_CYCLES = OSC_HALT_TIME_US * (SYS_CLK_HZ / 1_000_000);
    localparam logic [5:0] TRIM_SECS_SHORT = 6'h14;
    localparam logic [5:0] TRIM_SECS_LONG = 6'h3c;

    // ========================================================================
    // trim value coding (7-bit two's complement, 2 oscillator ticks per step)
    localparam logic [6:0] TRIM_POS_MIN = 7'h02;
    localparam logic [6:0] TRIM_POS_MAX = 7'h3f;
    localparam logic [6:0] TRIM_NEG_MIN = 7'h42;
    localparam logic [6:0] TRIM_ONE = 7'h01;
    localparam logic [6:0] TRIM_ZERO = 7'h00;

endpackage

// file: logic/level_sync.sv
// two flip-flop synchroniser for asynchronous levels
// assumes inputs change slowly against clk_sys
module level_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    // ========================================================================
    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            stable_q <= '0;
        end else begin
            meta_q <= din;
            stable_q <= meta_q;
        end
    end

    assign dout = stable_q;

endmodule

// file: logic/rtc_status_monitor_fix.sv
// holds no logic: the monitor and its synchroniser live in their own files

// file: verification/rtc_status_monitor_props.sv
// assertion checker for the ports of the rtc status monitor
// assumes host writes and event pulses change just after clk_sys edges
module rtc_status_monitor_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic weekly_alarm_match,
    input wire logic daily_alarm_match,
    input wire logic second_tick,
    input wire logic hour_format,
    input wire logic test_mode,
    input wire logic clock_out_active,
    input wire logic supply_sample_en,
    input wire logic irq_n_pin_o,
    input wire logic irq_n_pin_oe
);
    // ========================================================================
    // shadow of pon and interrupt enables, rebuilt from observed writes
    logic pon_q;
    logic wen_q;
    logic [2:0] psel_q;
    logic wr_e;
    logic wr_f;
    logic quiet;
    assign wr_e = reg_wr && reg_addr == 4'he && !pon_q;
    assign wr_f = reg_wr && reg_addr == 4'hf && !reg_wdata[4];
    assign quiet = !(weekly_alarm_match || daily_alarm_match || reg_wr);

    // enables only take writes once pon already reads 0
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pon_q <= 1'b1;
            wen_q <= 1'b0;
            psel_q <= 3'h0;
        end else begin
            pon_q <= pon_q && !wr_f;
            wen_q <= wr_e ? reg_wdata[7] : wen_q;
            psel_q <= wr_e ? reg_wdata[2:0] : psel_q;
        end
    end

    // ========================================================================
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property flag_release;
        !weekly_alarm_match && !daily_alarm_match && reg_wr && reg_addr == 4'hf && reg_wdata[2:0] == 3'h0
            && psel_q == 3'h0 ##1 quiet [*2]
            |=> !irq_n_pin_oe;
    endproperty

    pin_data_zero_a: assert property (irq_n_pin_o == 1'b0)
        else $error("interrupt pin data not low");
    pon_readback_a: assert property ($past(rst_n) && $past(pon_q) && $past(reg_addr) == 4'hf
        |-> (reg_rdata & 8'hdf) == 8'h10) else $error("status register wrong while pon set");
    ctrl_cleared_a: assert property ($past(rst_n) && $past(pon_q) && $past(reg_addr) inside {4'he, 4'h7}
        |-> reg_rdata == 8'h00) else $error("control or trim not cleared while pon set");
    outputs_held_a: assert property ($past(rst_n) && $past(pon_q)
        |-> !hour_format && !test_mode && !supply_sample_en && clock_out_active)
        else $error("control outputs not held while pon set");
    alarm_pin_a: assert property (weekly_alarm_match && wen_q |-> ##2 irq_n_pin_oe)
        else $error("weekly alarm did not pull the pin");
    flag_release_a: assert property (flag_release)
        else $error("pin still pulled after flags cleared");
    fixed_low_a: assert property ($past(psel_q) == 3'h1 && psel_q == 3'h1 |-> irq_n_pin_oe)
        else $error("fixed low code left the pin released");
    tick_pulse_a: assert property (second_tick |=> !second_tick)
        else $error("second tick longer than one cycle");

    cover property (weekly_alarm_match && wen_q);
    cover property (psel_q == 3'h1 && irq_n_pin_oe);
    cover property ($fell(pon_q));
endmodule

bind rtc_status_monitor rtc_status_monitor_props props (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .weekly_alarm_match(weekly_alarm_match),
    .daily_alarm_match(daily_alarm_match), .second_tick(second_tick), .hour_format(hour_format),
    .test_mode(test_mode), .clock_out_active(clock_out_active), .supply_sample_en(supply_sample_en),
    .irq_n_pin_o(irq_n_pin_o), .irq_n_pin_oe(irq_n_pin_oe));

// file: verification/rtc_host_model.sv
// host cpu model: register writes and reads through the serial engine port
// assumes a one-cycle write strobe and read data one edge behind the address
module rtc_host_model (
    input wire logic clk_sys,
    output logic reg_wr,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
    end

    // data turns to its inverse once the strobe is gone, so stale data never matches
    task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~data;
    endtask

    // address held two edges so the registered read data has settled
    task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
        @(posedge clk_sys);
        #1;
        reg_addr = addr;
        @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        data = reg_rdata;
    endtask
endmodule

// file: verification/rtc_status_monitor_tb.sv
// self-checking bench for the rtc status monitor
// assumes the host model owns the register port and the bench drives events
module rtc_status_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // stimulus and observation
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic osc_clk = 1'b0;
    logic osc_run = 1'b1;
    logic below_1v6 = 1'b0;
    logic below_1v3 = 1'b0;
    logic [4:0] ev = 5'h00;
    logic reg_wr, second_tick, hour_format, test_mode, clock_out_active, supply_sample_en, irq_o, irq_oe;
    logic irq_level;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    int mismatches = 0;
    int samples_checked = 0;

    always #4 clk_sys = ~clk_sys;
    // a stopped oscillator models a halt
    always #80 if (osc_run) osc_clk = ~osc_clk;
    assign irq_level = irq_oe ? irq_o : 1'b1;

    rtc_status_monitor #(.OSC_HALT_LIMIT(64)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .osc_clk(osc_clk),
        .supply_below_1v6(below_1v6), .supply_below_1v3(below_1v3), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .weekly_alarm_match(ev[0]), .daily_alarm_match(ev[1]),
        .minute_rollover(ev[2]), .hour_rollover(ev[3]), .month_rollover(ev[4]), .second_tick(second_tick),
        .hour_format(hour_format), .test_mode(test_mode), .clock_out_active(clock_out_active),
        .supply_sample_en(supply_sample_en), .irq_n_pin_o(irq_o), .irq_n_pin_oe(irq_oe));
    rtc_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));

    // ========================================================================
    // comparisons and shared steps
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: register read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: output %b expected %b", $time, got, exp);
        end
    endtask
    task automatic expect_reg(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
        host.read_reg(a, rd);
        check_reg(rd & mask, exp);
    endtask
    // bit 0 weekly, 1 daily, 2 minute, 3 hour, 4 month
    task automatic pulse(input logic [4:0] which);
        @(posedge clk_sys);
        #1;
        ev = which;
        @(posedge clk_sys);
        #1;
        ev = 5'h00;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
    endtask
    task automatic stop_test;
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ========================================================================
    // scenarios
    // power-up state; everything but clearing pon and writing oscr is refused while it is set
    task automatic test_power_on;
        expect_reg(4'hf, 8'hdf, 8'h10);
        host.write_reg(4'he, 8'hff);
        host.write_reg(4'h7, 8'hff);
        host.write_reg(4'hf, 8'hff);
        expect_reg(4'he, 8'hff, 8'h00);
        expect_reg(4'h7, 8'hff, 8'h00);
        expect_reg(4'hf, 8'hdf, 8'h10);
        check_pin(irq_level, 1'b1);
        host.write_reg(4'hf, 8'h20);
        expect_reg(4'hf, 8'hff, 8'h20);
    endtask
    // threshold select, then the sticky flag stops sampling
    task automatic test_supply;
        check_pin(supply_sample_en, 1'b1);
        host.write_reg(4'hf, 8'ha0);
        below_1v6 = 1'b1;
        repeat (600) @(posedge clk_sys);
        expect_reg(4'hf, 8'hff, 8'ha0);
        below_1v3 = 1'b1;
        repeat (600) @(posedge clk_sys);
        expect_reg(4'hf, 8'hff, 8'he0);
        check_pin(supply_sample_en, 1'b0);
        // comparators recover before the clear, else the open window sets the flag again
        below_1v6 = 1'b0;
        below_1v3 = 1'b0;
        host.write_reg(4'hf, 8'h20);
        expect_reg(4'hf, 8'h40, 8'h00);
        check_pin(supply_sample_en, 1'b1);
    endtask
    // a halted oscillator overrides a host write of 1
    task automatic test_osc_halt;
        osc_run = 1'b0;
        repeat (100) @(posedge clk_sys);
        host.write_reg(4'hf, 8'h20);
        expect_reg(4'hf, 8'h20, 8'h00);
        osc_run = 1'b1;
        repeat (40) @(posedge clk_sys);
        host.write_reg(4'hf, 8'h20);
        expect_reg(4'hf, 8'h20, 8'h20);
    endtask
    // flags are sticky and independent; only a 0 clears one
    task automatic test_alarms;
        host.write_reg(4'he, 8'hc0);
        pulse(5'h01);
        check_pin(irq_level, 1'b0);
        host.write_reg(4'hf, 8'h23);
        pulse(5'h02);
        expect_reg(4'hf, 8'h07, 8'h03);
        host.write_reg(4'hf, 8'h21);
        expect_reg(4'hf, 8'h07, 8'h01);
        check_pin(irq_level, 1'b0);
        host.write_reg(4'hf, 8'h20);
        expect_reg(4'hf, 8'h07, 8'h00);
        check_pin(irq_level, 1'b1);
        pulse(5'h01);
        expect_reg(4'he, 8'hff, 8'hc0);
        expect_reg(4'hf, 8'h07, 8'h02);
        host.write_reg(4'hf, 8'h20);
        host.write_reg(4'he, 8'h00);
        pulse(5'h03);
        expect_reg(4'hf, 8'h07, 8'h00);
        check_pin(irq_level, 1'b1);
    endtask
    // every code set; level codes flag only their own rollover
    task automatic test_periodic;
        logic [4:0] mine;
        for (int c = 0; c < 8; c++) begin
            host.write_reg(4'he, 8'(c));
            mine = (c >= 5) ? 5'(5'h04 << (c - 5)) : 5'h00;
            pulse(5'h1c & ~mine);
            // pulse codes start low at the second boundary; the run ends well inside the first quarter
            expect_reg(4'hf, 8'h04, 8'h00);
            check_pin(irq_level, 1'(c == 0 || c >= 4));
            if (c >= 5) begin
                pulse(mine);
                expect_reg(4'hf, 8'h04, 8'h04);
                check_pin(irq_level, 1'b0);
                host.write_reg(4'hf, 8'h20);
                expect_reg(4'hf, 8'h04, 8'h00);
                check_pin(irq_level, 1'b1);
            end
        end
        host.write_reg(4'he, 8'h00);
    endtask
    // a second power-up clears control and trim again
    task automatic test_repower;
        host.write_reg(4'he, 8'h38);
        host.write_reg(4'h7, 8'hc5);
        expect_reg(4'h7, 8'hff, 8'hc5);
        check_pin(hour_format & test_mode & clock_out_active, 1'b1);
        do_reset;
        expect_reg(4'he, 8'hff, 8'h00);
        expect_reg(4'h7, 8'hff, 8'h00);
        expect_reg(4'hf, 8'hdf, 8'h10);
    endtask

    // ========================================================================
    // main sequence and watchdog
    initial begin
        do_reset;
        test_power_on;
        test_supply;
        test_osc_halt;
        test_alarms;
        test_periodic;
        test_repower;
        stop_test;
    end
    initial begin
        #400000;
        mismatches++;
        stop_test;
    end
endmodule
